/* File: vlrc_pkg.sv */
// Shared constants, types and helpers for the video link retimer control
package vlrc_pkg;

   // Core clock rate and derived timing counts
   localparam int          CORE_CLK_KHZ     = 40000;
   localparam int          CORE_CLK_NS      = 25;
   localparam int          CDR_LOCK_MAX_MS  = 15;
   localparam int          CDR_LOCK_CYC     = CDR_LOCK_MAX_MS * CORE_CLK_KHZ;
   localparam int          CDR_OFF_MAX_NS   = 120;
   localparam int          CDR_OFF_CYC      = CDR_OFF_MAX_NS / CORE_CLK_NS;
   localparam int          LOCK_W           = 20;

   // Rate measurement window and edge thresholds (scaled link clock)
   localparam logic [7:0]  RATE_WINDOW_LAST = 8'h3F;
   localparam logic [7:0]  RETIMER_MIN_EDGES = 8'h04;
   localparam logic [7:0]  TERM_MIN_EDGES   = 8'h08;
   localparam logic [7:0]  SIG_MIN_EDGES    = 8'h01;

   // Lane layout: 0..2 data lanes, 3 clock lane
   localparam int          LANES            = 4;
   localparam int          DATA_LANES       = 3;
   localparam int          CLK_LANE         = 3;
   localparam int          FIFO_DEPTH       = 16;
   localparam int          ERR_W            = 16;
   localparam int          EYE_W            = 16;
   localparam logic [6:0]  PRBS_SEED        = 7'h7F;
   localparam logic [4:0]  I2C_ADDR_BASE    = 5'h0A; // Arbitrary value

   // Operating modes
   typedef enum logic [2:0] {
      MODE_OFF      = 3'b000,
      MODE_PDOWN    = 3'b001,
      MODE_STANDBY  = 3'b010,
      MODE_REDRIVE  = 3'b011,
      MODE_LOCKING  = 3'b100,
      MODE_RETIME   = 3'b101
   } vlrc_mode_t;

   // Software configuration word
   typedef struct packed {
      logic       swapEn;
      logic       polEn;
      logic       powerDown;
      logic       sigDetEn;
      logic       ddcFast;
      logic       prbsEn;
      logic       checkEn;
      logic [1:0] eyeLane;
   } vlrc_cfg_t;

   // Rate meter verdict
   typedef struct packed {
      logic sigValid;
      logic rateHigh;
      logic termHigh;
   } vlrc_rate_t;

   // One PRBS7 step
   function automatic logic [6:0] vlrc_prbs_step(input logic [6:0] s);
      return {s[5:0], s[6] ^ s[5]};
   endfunction

   // Input lane swap mapping, index is output lane
   function automatic logic [3:0] vlrc_lane_map(input logic [3:0] in, input logic swap);
      return swap ? {in[2], in[3], in[0], in[1]} : in;
   endfunction

endpackage

/* File: vlrc_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module vlrc_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   // DEPTH must be a power of two so pointers wrap naturally
   localparam int         AW   = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } vlrc_fifo_state_t;

   vlrc_fifo_state_t s_reg;
   vlrc_fifo_state_t s_next;
   logic             push;
   logic             pop;

   // Honest flags from the occupancy count
   assign inReady  = (s_reg.cnt != FULL);
   assign outValid = (s_reg.cnt != '0);
   assign outData  = s_reg.mem[s_reg.rd];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Pointer and storage update
   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wr] = inData;
         s_next.wr            = s_reg.wr + AW'(1);
      end
      if (pop) begin
         s_next.rd = s_reg.rd + AW'(1);
      end
      s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: vlrc_rate_meter.sv */
// Link clock edge counter that classifies the incoming rate
`timescale 1ns/1ps
module vlrc_rate_meter
   import vlrc_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  edgePulse,
   output vlrc_rate_t rate,
   output logic       rateChanged
);
   typedef struct packed {
      logic [7:0] win;
      logic [7:0] edges;
      vlrc_rate_t rate;
      logic       changed;
   } vlrc_meter_state_t;

   vlrc_meter_state_t s_reg;
   vlrc_meter_state_t s_next;
   vlrc_rate_t        verdict;

   assign rate        = s_reg.rate;
   assign rateChanged = s_reg.changed;

   // Count edges per window, judge at window end
   always_comb begin
      s_next         = s_reg;
      s_next.changed = 1'h0;
      verdict.sigValid = s_reg.edges >= SIG_MIN_EDGES;
      verdict.rateHigh = s_reg.edges >= RETIMER_MIN_EDGES;
      verdict.termHigh = s_reg.edges >= TERM_MIN_EDGES;
      if (s_reg.win == RATE_WINDOW_LAST) begin
         s_next.win     = '0;
         s_next.edges   = 8'(edgePulse);
         s_next.rate    = verdict;
         s_next.changed = (verdict != s_reg.rate);   // see (RULE23)
      end else begin
         s_next.win = s_reg.win + 8'h01;
         if (edgePulse && s_reg.edges != 8'hFF) begin
            s_next.edges = s_reg.edges + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: vlrc_core.sv */
// Retimer control core: modes, lane mapping, retiming path and debug tools
//
// How it works
// (RULE1) Redriver below rate threshold, retimer above it
// (RULE2) I2C mode address taken from two straps
// (RULE3) Power down on HPD low, bit, or CE low
// (RULE4) CE low discards software config; straps persist
// (RULE5) Signal detect on: standby without valid input
// (RULE6) Signal detect off after reset; pin or software
// (RULE7) DDC bridge slow by default, software selects fast
// (RULE8) Floating termination pin: termination follows measured rate
// (RULE9) CE low: controls ignored, lanes high impedance
// (RULE10) Controller holds CE low 100 us first
// (RULE11) Controller keeps CE low 100 us after rails
// (RULE12) CDR active within 15 ms of retimer start
// (RULE13) CDR off within 120 ns of retimer end
// (RULE14) Swap pin low or bit: D2/CLK, D1/D0 exchange
// (RULE15) Swap remaps inputs; lane settings follow lanes
// (RULE16) Swap works in redriver and retimer
// (RULE17) Pin high inverts every lane, retimer only
// (RULE18) Crossover down to redriver loses polarity inversion
// (RULE19) Software may combine swap and polarity in retimer
// (RULE20) Per data lane error checker with counts
// (RULE21) Per lane eye sample readout
// (RULE22) Internal PRBS on data outputs, paced by clock lane
// (RULE23) Mode follows measured clock lane frequency changes
`timescale 1ns/1ps
module vlrc_core
   import vlrc_pkg::*;
#(
   parameter int unsigned LOCK_CYC = CDR_LOCK_CYC
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic [LANES-1:0]            laneInPin,
   input  wire logic                        chipEnablePin,
   input  wire logic                        hotPlugPin,
   input  wire logic                        laneSwapPolarityPin,
   input  wire logic                        signalDetectEnablePin,
   input  wire logic                        txTerminationSelectFloat,
   input  wire logic                        txTerminationSelectHigh,
   input  wire logic [1:0]                  addressStrapPins,
   input  wire logic                        i2cModePin,
   input  wire logic                        sinkReadyPin,
   input  wire logic                        cfgWrite,
   input  wire vlrc_cfg_t                   cfgWord,
   output logic      [LANES-1:0]            laneOut,
   output logic                             laneOe,
   output logic                             termEnable,
   output logic                             retimerMode,
   output logic                             cdrActive,
   output logic                             powerDown,
   output logic                             standby,
   output logic      [6:0]                  i2cAddress,
   output logic                             ddcFast,
   output logic      [DATA_LANES-1:0][ERR_W-1:0] errCount,
   output logic      [EYE_W-1:0]            eyeSample,
   output logic                             overflowSeen
);

   ////////////////////////////////////////////////////////////////////////
   // State of the core

   typedef struct packed {
      logic [LANES-1:0]                  sync1Lane;
      logic [LANES-1:0]                  sync2Lane;
      logic                              sync1Ce;
      logic                              sync2Ce;
      logic                              sync1Hpd;
      logic                              sync2Hpd;
      logic                              sync1Swp;
      logic                              sync2Swp;
      logic                              sync1Sig;
      logic                              sync2Sig;
      logic [1:0]                        sync1Term;
      logic [1:0]                        sync2Term;
      logic [1:0]                        sync1Addr;
      logic [1:0]                        sync2Addr;
      logic                              sync1I2c;
      logic                              sync2I2c;
      logic                              sync1Rdy;
      logic                              sync2Rdy;
      logic                              prevClk;
      vlrc_cfg_t                         cfg;
      vlrc_mode_t                        mode;
      logic [LOCK_W-1:0]                 lockCnt;
      logic                              polLost;
      logic [6:0]                        prbs;
      logic [DATA_LANES-1:0][6:0]        chkHist;
      logic [DATA_LANES-1:0][ERR_W-1:0]  errCount;
      logic [EYE_W-1:0]                  eyeShift;
      logic [LANES-1:0]                  laneOut;
      logic                              laneOe;
      logic                              termEnable;
      logic                              retimerMode;
      logic                              cdrActive;
      logic                              powerDown;
      logic                              standby;
      logic [6:0]                        i2cAddress;
      logic                              ddcFast;
      logic                              overflowSeen;
   } vlrc_core_state_t;

   vlrc_core_state_t s_reg;
   vlrc_core_state_t s_next;

   ////////////////////////////////////////////////////////////////////////
   // Combinational helpers

   logic             swapReq;
   logic             polReq;
   logic             polActive;
   logic [LANES-1:0] mapped;
   logic             linkClk;
   logic             clkEdge;
   vlrc_rate_t       rate;
   logic             sigDetOn;
   logic             fifoInValid;
   logic             fifoInReady;
   logic [LANES-1:0] fifoInData;
   logic             fifoOutValid;
   logic             fifoOutReady;
   logic [LANES-1:0] fifoOutData;
   logic             retiming;

   // Pin low swaps, pin high inverts; software may add either
   assign swapReq   = !s_reg.sync2Swp || s_reg.cfg.swapEn;          // see (RULE14)
   assign polReq    = s_reg.sync2Swp || s_reg.cfg.polEn;            // see (RULE19)
   assign polActive = s_reg.retimerMode && polReq && !s_reg.polLost; // see (RULE17)

   // Remap, then invert; per-lane settings travel with the mapped lane
   assign mapped  = vlrc_lane_map(s_reg.sync2Lane, swapReq)
                    ^ {LANES{polActive}};                          // see (RULE15)
   assign linkClk = mapped[CLK_LANE];
   assign clkEdge = linkClk && !s_reg.prevClk;

   // Detect enable from strap or software, off from reset
   assign sigDetOn = s_reg.sync2Sig || s_reg.cfg.sigDetEn;        // see (RULE6)

   // Retiming path feeds the FIFO on clock lane edges
   assign retiming     = (s_reg.mode == MODE_RETIME);
   assign fifoInValid  = clkEdge && retiming;
   assign fifoOutReady = s_reg.sync2Rdy && retiming;
   // PRBS replaces data lanes; clock lane sets the pace
   assign fifoInData   = s_reg.cfg.prbsEn
                         ? {linkClk, s_reg.prbs[4], s_reg.prbs[2], s_reg.prbs[0]}
                         : mapped;                                 // see (RULE22)

   ////////////////////////////////////////////////////////////////////////
   // Submodules

   // Frequency measurement of the mapped clock lane
   vlrc_rate_meter u_meter (
      .clk         (core_clk),
      .rst_n       (rst_n),
      .edgePulse   (clkEdge),
      .rate        (rate),
      .rateChanged ()
   );

   // Retiming buffer between link edges and sink pacing
   vlrc_fifo #(
      .WIDTH (LANES),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (core_clk),
      .rst_n    (rst_n),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (fifoInData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from state

   assign laneOut      = s_reg.laneOut;
   assign laneOe       = s_reg.laneOe;
   assign termEnable   = s_reg.termEnable;
   assign retimerMode  = s_reg.retimerMode;
   assign cdrActive    = s_reg.cdrActive;
   assign powerDown    = s_reg.powerDown;
   assign standby      = s_reg.standby;
   assign i2cAddress   = s_reg.i2cAddress;
   assign ddcFast      = s_reg.ddcFast;
   assign errCount     = s_reg.errCount;
   assign eyeSample    = s_reg.eyeShift;
   assign overflowSeen = s_reg.overflowSeen;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      logic [6:0] chkPredict;
      chkPredict = '0;
      s_next = s_reg;

      // Two-stage synchronisers for all pins
      s_next.sync1Lane = laneInPin;
      s_next.sync2Lane = s_reg.sync1Lane;
      s_next.sync1Ce   = chipEnablePin;
      s_next.sync2Ce   = s_reg.sync1Ce;
      s_next.sync1Hpd  = hotPlugPin;
      s_next.sync2Hpd  = s_reg.sync1Hpd;
      s_next.sync1Swp  = laneSwapPolarityPin;
      s_next.sync2Swp  = s_reg.sync1Swp;
      s_next.sync1Sig  = signalDetectEnablePin;
      s_next.sync2Sig  = s_reg.sync1Sig;
      s_next.sync1Term = {txTerminationSelectFloat, txTerminationSelectHigh};
      s_next.sync2Term = s_reg.sync1Term;
      s_next.sync1Addr = addressStrapPins;
      s_next.sync2Addr = s_reg.sync1Addr;
      s_next.sync1I2c  = i2cModePin;
      s_next.sync2I2c  = s_reg.sync1I2c;
      s_next.sync1Rdy  = sinkReadyPin;
      s_next.sync2Rdy  = s_reg.sync1Rdy;
      s_next.prevClk   = linkClk;

      // Software configuration, accepted only while enabled
      if (!s_reg.sync2Ce) begin
         s_next.cfg = '0;                                          // see (RULE4)
      end else if (cfgWrite) begin
         s_next.cfg = cfgWord;                                     // see (RULE9)
      end
      s_next.ddcFast = s_reg.cfg.ddcFast;                          // see (RULE7)

      // Bus address from straps in I2C mode
      if (s_reg.sync2Ce && s_reg.sync2I2c) begin
         s_next.i2cAddress = {I2C_ADDR_BASE, s_reg.sync2Addr};     // see (RULE2)
      end

      // Mode selection driven by enable, power and measured rate
      if (!s_reg.sync2Ce) begin
         s_next.mode = MODE_OFF;                                   // see (RULE9)
      end else if (!s_reg.sync2Hpd || s_reg.cfg.powerDown) begin
         s_next.mode = MODE_PDOWN;                                 // see (RULE3)
      end else if (sigDetOn && !rate.sigValid) begin
         s_next.mode = MODE_STANDBY;                               // see (RULE5)
      end else if (rate.rateHigh) begin                            // see (RULE1)
         case (s_reg.mode)
            MODE_LOCKING: begin
               if (s_reg.lockCnt >= LOCK_W'(LOCK_CYC - 1)) begin
                  s_next.mode = MODE_RETIME;                       // see (RULE12)
               end else begin
                  s_next.lockCnt = s_reg.lockCnt + LOCK_W'(1);
               end
            end
            MODE_RETIME: begin
               s_next.mode = MODE_RETIME;
            end
            default: begin
               s_next.mode    = MODE_LOCKING;                      // see (RULE23)
               s_next.lockCnt = '0;
            end
         endcase
      end else begin
         s_next.mode = MODE_REDRIVE;                               // see (RULE23)
      end

      // Falling back from retiming on rate drops polarity
      if (s_reg.mode == MODE_RETIME && s_next.mode == MODE_REDRIVE && polReq) begin
         s_next.polLost = 1'h1;                                    // see (RULE18)
      end else if (!polReq || !s_reg.sync2Ce) begin
         s_next.polLost = 1'h0;
      end

      // Status flags; CDR drops in the same cycle as retimerMode when retiming ends
      s_next.retimerMode = (s_next.mode == MODE_RETIME) || (s_next.mode == MODE_LOCKING);
      s_next.cdrActive   = (s_next.mode == MODE_RETIME);           // see (RULE13)
      s_next.powerDown   = (s_next.mode == MODE_PDOWN) || (s_next.mode == MODE_OFF);
      s_next.standby     = (s_next.mode == MODE_STANDBY);
      s_next.laneOe      = (s_next.mode == MODE_RETIME) || (s_next.mode == MODE_REDRIVE);

      // Termination: auto from rate when floating, off when the pin is driven high or low
      s_next.termEnable = s_reg.sync2Term[1] && rate.termHigh && s_next.laneOe; // see (RULE8)

      // Lane output: straight through or from the retiming buffer
      case (s_reg.mode)
         MODE_REDRIVE: begin
            s_next.laneOut = mapped;                               // see (RULE16)
         end
         MODE_RETIME: begin
            if (fifoOutValid && fifoOutReady) begin
               s_next.laneOut = fifoOutData;
            end
         end
         default: begin
            s_next.laneOut = '0;
         end
      endcase

      // Buffer overrun when the sink stalls; a new overrun beats the clear
      if (fifoInValid && !fifoInReady) begin
         s_next.overflowSeen = 1'h1;
      end else if (!s_reg.sync2Ce) begin
         s_next.overflowSeen = 1'h0;
      end

      // PRBS generator advances on clock lane edges
      if (!s_reg.cfg.prbsEn) begin
         s_next.prbs = PRBS_SEED;
      end else if (clkEdge) begin
         s_next.prbs = vlrc_prbs_step(s_reg.prbs);                 // see (RULE22)
      end

      // Self-synchronising PRBS checker per data lane
      for (int i = 0; i < DATA_LANES; i++) begin
         if (!s_reg.cfg.checkEn) begin
            s_next.chkHist[i]  = '0;
            s_next.errCount[i] = '0;
         end else if (clkEdge && retiming) begin
            s_next.chkHist[i] = {s_reg.chkHist[i][5:0], mapped[i]};
            chkPredict        = vlrc_prbs_step(s_reg.chkHist[i]);
            if (mapped[i] != chkPredict[0]
                && s_reg.errCount[i] != '1) begin
               s_next.errCount[i] = s_reg.errCount[i] + ERR_W'(1); // see (RULE20)
            end
         end
      end

      // Eye sample history of the selected lane
      if (clkEdge && s_reg.laneOe) begin
         s_next.eyeShift = {s_reg.eyeShift[EYE_W-2:0], mapped[s_reg.cfg.eyeLane]}; // see (RULE21)
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule

/* File: vlrc_src_model.sv */
// Video source model driving the link clock lane and data lanes
`timescale 1ns/1ps
module vlrc_src_model (
   input  wire logic       run,
   input  wire logic       slow,
   input  wire logic [2:0] dataPat,
   output logic      [3:0] laneIn
);
   logic linkClk = 1'b0;
   // Clock lane on top, static data lanes below
   assign laneIn = {linkClk, dataPat};
   // Link clock paces the output rate, still outside frames
   initial begin
      forever begin
         if (run) begin
            #(slow ? 400 : 100);
            linkClk = ~linkClk;
         end else begin
            linkClk = 1'b0;
            @(posedge run);
            #5; // Keep link edges off the core clock edges
         end
      end
   end
endmodule

/* File: vlrc_core_assertions.sv */
// Concurrent checks on the retimer control core ports
`timescale 1ns/1ps
module vlrc_core_assertions
   import vlrc_pkg::*;
#(
   parameter int unsigned LOCK_CYC = CDR_LOCK_CYC
) (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       chipEnablePin,
   input wire logic       hotPlugPin,
   input wire logic       txTerminationSelectFloat,
   input wire logic [1:0] addressStrapPins,
   input wire logic       i2cModePin,
   input wire logic       laneOe,
   input wire logic       termEnable,
   input wire logic       retimerMode,
   input wire logic       cdrActive,
   input wire logic       powerDown,
   input wire logic       standby,
   input wire logic [6:0] i2cAddress,
   input wire logic       overflowSeen
);
   logic [LOCK_W-1:0] lockCnt_reg;
   // Cycles spent locking without an active CDR
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lockCnt_reg <= '0;
      end else begin
         lockCnt_reg <= (retimerMode && !cdrActive) ? lockCnt_reg + 1'b1 : '0;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_ce_low_off: assert property ((!chipEnablePin) [*6] |-> powerDown && !laneOe)
      else $error("lanes driven with chip enable low");
   a_hpd_low_pdown: assert property ((!hotPlugPin) [*6] |-> powerDown && !retimerMode)
      else $error("no power down with hot plug low");
   a_term_pin_off: assert property ((!txTerminationSelectFloat) [*5] |-> !termEnable)
      else $error("termination on with pin not floating");
   a_cdr_off_bound: assert property ($fell(retimerMode) |-> ##[0:4] !cdrActive)
      else $error("recovery still on after retiming ended");
   a_cdr_in_retime: assert property (cdrActive |-> retimerMode)
      else $error("recovery active outside retiming");
   a_lock_time: assert property (lockCnt_reg <= LOCK_CYC + 4)
      else $error("recovery lock took too long");
   a_standby_quiet: assert property (standby |-> !laneOe && !cdrActive)
      else $error("lanes active in standby");
   a_oe_awake: assert property (laneOe |-> !powerDown && !standby)
      else $error("lanes driven while asleep");
   a_addr_strap: assert property ((i2cModePin && chipEnablePin && $stable(addressStrapPins)) [*6]
      |-> i2cAddress == {I2C_ADDR_BASE, addressStrapPins})
      else $error("bus address does not follow straps");
   c_cdr_up: cover property (cdrActive);
   c_standby: cover property (standby);
   c_overflow: cover property (overflowSeen);
   c_cross_down: cover property ($fell(retimerMode));
endmodule
bind vlrc_core vlrc_core_assertions #(.LOCK_CYC(LOCK_CYC)) chk (.core_clk(core_clk),
   .rst_n(rst_n), .chipEnablePin(chipEnablePin), .hotPlugPin(hotPlugPin),
   .txTerminationSelectFloat(txTerminationSelectFloat), .addressStrapPins(addressStrapPins),
   .i2cModePin(i2cModePin), .laneOe(laneOe), .termEnable(termEnable),
   .retimerMode(retimerMode), .cdrActive(cdrActive), .powerDown(powerDown),
   .standby(standby), .i2cAddress(i2cAddress), .overflowSeen(overflowSeen));

/* File: tb_top.sv */
// Self-checking bench for the retimer control core
`timescale 1ns/1ps
module tb_top
   import vlrc_pkg::*;
;
   logic       core_clk = 0, rst_n = 0, ce = 0, hpd = 1, swapPol = 1, sdet = 0, cfgWrite = 0;
   logic       termFloat = 1, termHigh = 0, i2cMode = 1, sinkReady = 1, run = 0, slow = 0;
   logic [2:0] dataPat = 3'b110;
   logic [1:0] straps = 2'b10;
   vlrc_cfg_t  cfgWord = '0;
   logic [3:0] laneIn, laneOut;
   logic [2:0][15:0] errs;
   logic [15:0] eye;
   logic       laneOe, termEnable, retimerMode, cdrActive, powerDown, standby, ddcFast, ovf;
   int         err_count = 0, samples_checked = 0, cyc = 0;
   vlrc_src_model src (.run(run), .slow(slow), .dataPat(dataPat), .laneIn(laneIn));
   vlrc_core #(.LOCK_CYC(20)) dut (.core_clk(core_clk), .rst_n(rst_n), .laneInPin(laneIn),
      .chipEnablePin(ce), .hotPlugPin(hpd), .laneSwapPolarityPin(swapPol),
      .signalDetectEnablePin(sdet), .txTerminationSelectFloat(termFloat),
      .txTerminationSelectHigh(termHigh), .addressStrapPins(straps), .i2cModePin(i2cMode),
      .sinkReadyPin(sinkReady), .cfgWrite(cfgWrite), .cfgWord(cfgWord), .laneOut(laneOut),
      .laneOe(laneOe), .termEnable(termEnable), .retimerMode(retimerMode),
      .cdrActive(cdrActive), .powerDown(powerDown), .standby(standby), .i2cAddress(),
      .ddcFast(ddcFast), .errCount(errs), .eyeSample(eye), .overflowSeen(ovf));
   // Core clock and hang guard
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         conclude();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic check(input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: saw %b expected %b", $time, seen, exp);
      end
   endtask
   task automatic waitFor(ref logic s, input logic v);
      for (int i = 0; i < 700 && s !== v; i++) tick(1);
   endtask
   task automatic writeCfg(input logic [8:0] w);
      tick(1);
      cfgWrite <= 1'b1;
      cfgWord  <= w;
      tick(1);
      cfgWrite <= 1'b0;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      tick(5);
      rst_n <= 1'b1;
      tick(4000); // Chip enable low long enough
      check(laneOe, 1'b0);
      ce <= 1'b1;
      tick(12);
      check(laneOe, 1'b1);
      check(ddcFast, 1'b0);
      sdet <= 1'b1;
      tick(200);
      check(standby, 1'b1);
      $display("idle test finished");
      run  <= 1'b1;
      slow <= 1'b1;
      sdet <= 1'b0; // Swapped clock lane carries no edges
      for (int k = 0; k < 3; k++) begin
         tick(1);
         swapPol <= (k != 1);
         writeCfg((k == 2) ? 9'h100 : 9'h000);
         tick(150);
         check(laneOut[1:0] === ((k == 0) ? 2'b10 : 2'b01), 1'b1);
         check(retimerMode, 1'b0);
      end
      $display("swap test finished");
      writeCfg(9'h000);
      slow <= 1'b0;
      waitFor(cdrActive, 1'b1);
      check(cdrActive, 1'b1);
      check(termEnable, 1'b1);
      // Inverted static lanes: lane 0 reads ones, lane 1 reads zeros
      writeCfg(9'h004);
      tick(200);
      check(errs[0] != 16'h0000, 1'b1);
      check(errs[1] == 16'h0000, 1'b1);
      check(eye === 16'hFFFF, 1'b1);
      termFloat <= 1'b0;
      termHigh  <= 1'b1;
      sinkReady <= 1'b0;
      tick(200);
      check(termEnable, 1'b0);
      check(ovf, 1'b1);
      sinkReady <= 1'b1;
      termFloat <= 1'b1;
      slow      <= 1'b1;
      waitFor(retimerMode, 1'b0);
      tick(4);
      check(cdrActive, 1'b0);
      $display("rate test finished");
      writeCfg(9'h010);
      tick(3);
      check(ddcFast, 1'b1);
      writeCfg(9'h050);
      tick(8);
      check(powerDown, 1'b1);
      writeCfg(9'h010);
      hpd <= 1'b0;
      tick(8);
      check(powerDown, 1'b1);
      hpd <= 1'b1;
      tick(8);
      check(powerDown, 1'b0);
      ce <= 1'b0;
      tick(4000);
      check(ovf, 1'b0);
      ce <= 1'b1;
      tick(12);
      check(ddcFast, 1'b0);
      $display("power test finished");
      conclude();
   end
endmodule
